/* File: hw/eth_ctl_pkg.sv */
// constants, register map and types for the mac control block
// assumes a single 40 MHz core clock and an apb register bus
package eth_ctl_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] NET_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] RXQ_PTR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATS_BASE_OFS = 8'h10;
  localparam int WORD_LSB = 2;

  // ----------------------------------------------------------------
  // network control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 11;
  localparam int PHY_LOOPBACK_BIT = 0;
  localparam int INTERNAL_LOOPBACK_BIT = 1;
  localparam int RX_ENABLE_BIT = 2;
  localparam int TX_ENABLE_BIT = 3;
  localparam int MGMT_PORT_ENABLE_BIT = 4;
  localparam int STATS_CLEAR_BIT = 5;
  localparam int STATS_INCREMENT_BIT = 6;
  localparam int STATS_WRITE_UNLOCK_BIT = 7;
  localparam int FORCE_COLLISION_BIT = 8;
  localparam int TX_GO_BIT = 9;
  localparam int TX_STOP_BIT = 10;
  // write-only strobes are not stored
  localparam logic [CTRL_W-1:0] CTRL_STORE_MASK = 11'h19f;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  // ----------------------------------------------------------------
  // receive queue pointer
  // ----------------------------------------------------------------
  localparam int RXQ_WRAP_COUNT = 1024;
  localparam int RXQ_IDX_W = 10;
  localparam int DESC_STRIDE_LSB = 3;
  localparam logic [DATA_W-1:0] RXQ_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // loopback clocking and statistics
  // ----------------------------------------------------------------
  localparam int LOOP_CLK_DIV = 4;
  localparam int LOOP_DIV_W = 2;
  localparam int N_STATS_DEFAULT = 4;
  localparam int STAT_W_DEFAULT = 16;
  localparam int NIBBLE_W = 4;

  typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_HALTING} tx_state_e;

endpackage

/* File: hw/stats_if.sv */
// carrier between the control block and its statistics bank
// assumes both ends run on the same core clock
interface stats_if #(
  parameter int N_STATS = eth_ctl_pkg::N_STATS_DEFAULT,
  parameter int STAT_W = eth_ctl_pkg::STAT_W_DEFAULT
);
  logic clear;
  logic increment;
  logic wrEn;
  logic [eth_ctl_pkg::ADDR_W-1:0] idx;
  logic [STAT_W-1:0] wrData;
  logic [STAT_W-1:0] rdData;

  modport ctrl (output clear, output increment, output wrEn, output idx, output wrData,
                input rdData);
  modport bank (input clear, input increment, input wrEn, input idx, input wrData,
                output rdData);
endinterface

/* File: hw/stats_bank.sv */
// bank of statistics counters with test clear, increment and write
// assumes strobes on the carrier are single-cycle and synchronous
module stats_bank #(
  parameter int N_STATS = eth_ctl_pkg::N_STATS_DEFAULT,
  parameter int STAT_W = eth_ctl_pkg::STAT_W_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [N_STATS-1:0] statEvent,
  stats_if.bank sb
);
  import eth_ctl_pkg::*;

  if (N_STATS < 1 || N_STATS > 48 || STAT_W < 1 || STAT_W > DATA_W) begin : g_chk
    $error("stats_bank: unsupported counter count or width");
  end

  typedef struct packed {
    logic [N_STATS-1:0][STAT_W-1:0] cnt;
  } bank_s;

  bank_s q;
  bank_s d;

  // ----------------------------------------------------------------
  // counter update
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    for (int i = 0; i < N_STATS; i++) begin
      // clear all counters; event in same cycle still counts
      if (sb.clear) begin
        d.cnt[i] = STAT_W'(statEvent[i]);
      end else begin
        d.cnt[i] = q.cnt[i] + STAT_W'(statEvent[i]);
      end
      if (sb.increment) begin
        d.cnt[i] = d.cnt[i] + STAT_W'(1);
      end
      if (sb.wrEn && sb.idx == ADDR_W'(i)) begin
        d.cnt[i] = sb.wrData;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    sb.rdData = '0;
    for (int i = 0; i < N_STATS; i++) begin
      if (sb.idx == ADDR_W'(i)) begin
        sb.rdData = q.cnt[i];
      end
    end
  end

endmodule // stats_bank

/* File: hw/eth_mac_control.sv */
// network control and receive queue pointer of an ethernet mac, apb slave
// assumes mii-style nibble paths, synchronous inputs and one 40 MHz clock
module eth_mac_control #(
  parameter int N_STATS = eth_ctl_pkg::N_STATS_DEFAULT,
  parameter int STAT_W = eth_ctl_pkg::STAT_W_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eth_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [eth_ctl_pkg::DATA_W-1:0] pwdata,
  output logic [eth_ctl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // mac core side
  input wire logic [eth_ctl_pkg::NIBBLE_W-1:0] macTxd,
  input wire logic macTxEn,
  input wire logic txFrameActive,
  input wire logic rxBufferUsed,
  input wire logic rxDescWrap,
  input wire logic fullDuplexCfg,
  input wire logic [N_STATS-1:0] statEvent,
  output logic [eth_ctl_pkg::NIBBLE_W-1:0] macRxd,
  output logic macRxDv,
  output logic rxEnable,
  output logic rxFifoFlush,
  output logic txFifoFlush,
  output logic txQueueRestart,
  output logic txRun,
  output logic fullDuplex,
  output logic loopClkEn,
  // phy side
  input wire logic [eth_ctl_pkg::NIBBLE_W-1:0] phyRxd,
  input wire logic phyRxDv,
  output logic [eth_ctl_pkg::NIBBLE_W-1:0] phyTxd,
  output logic phyTxEn,
  output logic phyLoopback,
  output logic forceCollision,
  // management port
  input wire logic mgmtMdc,
  input wire logic mgmtMdioOut,
  input wire logic mgmtMdioOe_b,
  output logic mdc,
  output logic mdioOut,
  output logic mdioOe_b
);
  import eth_ctl_pkg::*;

  if (N_STATS < 1 || N_STATS > 48 || STAT_W < 1 || STAT_W > DATA_W) begin : g_chk
    $error("eth_mac_control: unsupported statistics configuration");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] rxqBase;
    logic [RXQ_IDX_W-1:0] rxqIdx;
    tx_state_e txState;
    logic [LOOP_DIV_W-1:0] divCnt;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    logic [NIBBLE_W-1:0] rxd;
    logic rxDv;
    logic rxFlush;
    logic txFlush;
    logic txRestart;
    logic txRun;
    logic fullDuplex;
    logic loopClkEn;
    logic [NIBBLE_W-1:0] phyTxd;
    logic phyTxEn;
    logic forceCollision;
    logic mdc;
    logic mdioOut;
    logic mdioOe_b;
  } ctl_s;

  ctl_s q;
  ctl_s d;

  logic access;
  logic wrCommit;
  logic hitCtrl;
  logic hitRxq;
  logic hitStats;
  logic [ADDR_W-1:0] statIdx;
  logic [DATA_W-1:0] rdVal;
  logic [DATA_W-1:0] rxqCur;
  logic [CTRL_W-1:0] wrCtrl;

  stats_if #(.N_STATS(N_STATS), .STAT_W(STAT_W)) sbus ();

  stats_bank #(.N_STATS(N_STATS), .STAT_W(STAT_W)) u_stats (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .statEvent(statEvent),
    .sb(sbus.bank)
  );

  // ----------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------
  assign access = psel && penable;
  assign wrCommit = access && q.pready && pwrite;
  assign hitCtrl = (paddr == NET_CTRL_OFS);
  assign hitRxq = (paddr == RXQ_PTR_OFS);
  assign statIdx = ADDR_W'((paddr - STATS_BASE_OFS) >> WORD_LSB);
  assign hitStats = (paddr >= STATS_BASE_OFS) && (paddr[WORD_LSB-1:0] == '0)
                    && (statIdx < ADDR_W'(N_STATS));
  assign wrCtrl = pwdata[CTRL_W-1:0];

  // current descriptor is list start plus buffers consumed
  assign rxqCur = q.rxqBase + DATA_W'({q.rxqIdx, {DESC_STRIDE_LSB{1'b0}}});

  always_comb begin
    rdVal = '0;
    if (hitCtrl) begin
      rdVal = DATA_W'(q.ctrl);
    end else if (hitRxq) begin
      rdVal = {rxqCur[DATA_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
    end else if (hitStats) begin
      rdVal = DATA_W'(sbus.rdData);
    end
  end

  // ----------------------------------------------------------------
  // statistics strobes
  // ----------------------------------------------------------------
  always_comb begin
    sbus.idx = statIdx;
    sbus.wrData = pwdata[STAT_W-1:0];
    sbus.clear = wrCommit && hitCtrl && wrCtrl[STATS_CLEAR_BIT];
    sbus.increment = wrCommit && hitCtrl && wrCtrl[STATS_INCREMENT_BIT];
    sbus.wrEn = wrCommit && hitStats && q.ctrl[STATS_WRITE_UNLOCK_BIT];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.rxFlush = 1'b0;
    d.txFlush = 1'b0;
    d.txRestart = 1'b0;

    // one wait state, then answer
    if (access && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !(hitCtrl || hitRxq || hitStats);
      d.prdata = pwrite ? '0 : rdVal;
    end

    if (wrCommit && hitCtrl) begin
      d.ctrl = wrCtrl & CTRL_STORE_MASK;
      // falling rx enable flushes rx fifo only
      if (q.ctrl[RX_ENABLE_BIT] && !wrCtrl[RX_ENABLE_BIT]) begin
        d.rxFlush = 1'b1;
      end
      // falling tx enable flushes and restarts tx queue
      if (q.ctrl[TX_ENABLE_BIT] && !wrCtrl[TX_ENABLE_BIT]) begin
        d.txFlush = 1'b1;
        d.txRestart = 1'b1;
      end
    end

    // receive queue pointer
    if (wrCommit && hitRxq) begin
      // low two bits ignored on write
      d.rxqBase = {pwdata[DATA_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
      d.rxqIdx = '0;
    end else if (rxBufferUsed) begin
      // wrap after 1024 buffers or on wrap bit
      if (rxDescWrap || q.rxqIdx == RXQ_IDX_W'(RXQ_WRAP_COUNT - 1)) begin
        d.rxqIdx = '0;
      end else begin
        d.rxqIdx = q.rxqIdx + RXQ_IDX_W'(1);
      end
    end

    // transmit control
    case (q.txState)
      TX_IDLE: begin
        if (wrCommit && hitCtrl && wrCtrl[TX_GO_BIT] && d.ctrl[TX_ENABLE_BIT]) begin
          d.txState = TX_RUN;
        end
      end
      TX_RUN: begin
        if (wrCommit && hitCtrl && wrCtrl[TX_STOP_BIT]) begin
          d.txState = txFrameActive ? TX_HALTING : TX_IDLE;
        end
      end
      TX_HALTING: begin
        if (!txFrameActive) begin
          d.txState = TX_IDLE;
        end
      end
      default: begin
        d.txState = TX_IDLE;
      end
    endcase
    if (!d.ctrl[TX_ENABLE_BIT]) begin
      d.txState = TX_IDLE;
    end
    d.txRun = (d.txState != TX_IDLE);

    // loopback clock enable at core clock over four
    if (q.ctrl[INTERNAL_LOOPBACK_BIT]) begin
      d.divCnt = q.divCnt + LOOP_DIV_W'(1);
      d.loopClkEn = (q.divCnt == LOOP_DIV_W'(LOOP_CLK_DIV - 1));
    end else begin
      d.divCnt = '0;
      d.loopClkEn = 1'b0;
    end

    // tx wrapped to rx, full duplex forced
    if (q.ctrl[INTERNAL_LOOPBACK_BIT]) begin
      d.rxd = macTxd;
      d.rxDv = macTxEn;
      d.fullDuplex = 1'b1;
      d.phyTxEn = 1'b0;
    end else begin
      d.rxd = phyRxd;
      d.rxDv = phyRxDv;
      d.fullDuplex = fullDuplexCfg;
      d.phyTxEn = macTxEn && q.ctrl[TX_ENABLE_BIT];
    end
    d.phyTxd = macTxd;
    // reception stops at once when disabled
    d.rxDv = d.rxDv && q.ctrl[RX_ENABLE_BIT];

    // back pressure jams in half duplex
    d.forceCollision = q.ctrl[FORCE_COLLISION_BIT] && !d.fullDuplex && phyRxDv
                       && q.ctrl[RX_ENABLE_BIT];

    if (q.ctrl[MGMT_PORT_ENABLE_BIT]) begin
      d.mdc = mgmtMdc;
      d.mdioOut = mgmtMdioOut;
      d.mdioOe_b = mgmtMdioOe_b;
    end else begin
      d.mdc = 1'b0;
      d.mdioOut = 1'b0;
      d.mdioOe_b = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.rxqBase <= RXQ_RESET;
      q.txState <= TX_IDLE;
      q.mdioOe_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign macRxd = q.rxd;
  assign macRxDv = q.rxDv;
  // receive enable to the mac core
  assign rxEnable = q.ctrl[RX_ENABLE_BIT];
  assign rxFifoFlush = q.rxFlush;
  assign txFifoFlush = q.txFlush;
  assign txQueueRestart = q.txRestart;
  assign txRun = q.txRun;
  assign fullDuplex = q.fullDuplex;
  assign loopClkEn = q.loopClkEn;
  assign phyTxd = q.phyTxd;
  assign phyTxEn = q.phyTxEn;
  assign phyLoopback = q.ctrl[PHY_LOOPBACK_BIT];
  assign forceCollision = q.forceCollision;
  assign mdc = q.mdc;
  assign mdioOut = q.mdioOut;
  assign mdioOe_b = q.mdioOe_b;

endmodule // eth_mac_control

/* File: testbench/eth_mac_control_assertions.sv */
// checker for the mac control block, attached to it by bind
// assumes writes commit at the pready edge and datapath outputs follow one edge later
module eth_mac_control_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eth_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [eth_ctl_pkg::DATA_W-1:0] pwdata,
  input wire logic [eth_ctl_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic macTxEn,
  input wire logic [eth_ctl_pkg::NIBBLE_W-1:0] macTxd,
  input wire logic [eth_ctl_pkg::NIBBLE_W-1:0] macRxd,
  input wire logic [eth_ctl_pkg::NIBBLE_W-1:0] phyTxd,
  input wire logic rxEnable,
  input wire logic mgmtMdc,
  input wire logic mgmtMdioOut,
  input wire logic mgmtMdioOe_b,
  input wire logic mdioOut,
  input wire logic phyRxDv,
  input wire logic macRxDv,
  input wire logic rxFifoFlush,
  input wire logic txFifoFlush,
  input wire logic txQueueRestart,
  input wire logic txRun,
  input wire logic fullDuplex,
  input wire logic loopClkEn,
  input wire logic phyTxEn,
  input wire logic phyLoopback,
  input wire logic forceCollision,
  input wire logic mdc,
  input wire logic mdioOe_b
);
  import eth_ctl_pkg::*;
  logic wrCtl;
  logic [CTRL_W-1:0] ctlQ;
  logic [CTRL_W-1:0] ctlD;
  assign wrCtl = psel && penable && pready && pwrite && paddr == NET_CTRL_OFS;
  // ------------------------------------------------------------
  // ctlQ mirrors the register; ctlD lags it one edge
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctlQ <= CTRL_RESET;
      ctlD <= CTRL_RESET;
    end else begin
      ctlQ <= wrCtl ? pwdata[CTRL_W-1:0] & CTRL_STORE_MASK : ctlQ;
      ctlD <= ctlQ;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_phy_loop_out: assert property (phyLoopback == ctlQ[0])
    else $error("loopback pin wrong");
  a_rx_enable_out: assert property (rxEnable == ctlQ[2])
    else $error("rx enable output wrong");
  a_loop_nibble: assert property (ctlD[1] |-> macRxd == $past(macTxd))
    else $error("loop nibble wrong");
  a_phy_tx_path: assert property ($past(rst_b) && !ctlD[1] |-> phyTxd == $past(macTxd)
    && phyTxEn == ($past(macTxEn) && ctlD[3])) else $error("phy tx path wrong");
  a_mgmt_port_on: assert property (ctlD[4] |-> mdc == $past(mgmtMdc)
    && mdioOut == $past(mgmtMdioOut) && mdioOe_b == $past(mgmtMdioOe_b))
    else $error("mgmt port not passed");
  a_loop_duplex: assert property (ctlD[1] |-> fullDuplex && !phyTxEn)
    else $error("loop not full duplex");
  a_loop_data: assert property (ctlD[1] && ctlD[2] |-> macRxDv == $past(macTxEn))
    else $error("loop data path wrong");
  a_loop_clk_rate: assert property (loopClkEn |-> ctlD[1] ##1 !loopClkEn [*3]
    ##1 (loopClkEn || !ctlD[1])) else $error("loop clock not div four");
  a_rx_flush_once: assert property ($fell(ctlQ[2]) |-> rxFifoFlush)
    else $error("rx flush missing");
  a_tx_flush_stop: assert property ($fell(ctlQ[3]) |->
    (txFifoFlush && txQueueRestart && !txRun) ##1 !txRun) else $error("tx stop wrong");
  a_mgmt_port_off: assert property (!ctlD[4] |-> mdioOe_b && !mdc)
    else $error("mgmt port not idle");
  a_back_press: assert property (forceCollision ==
    (ctlD[8] && ctlD[2] && !fullDuplex && $past(phyRxDv))) else $error("collision wrong");
  a_tx_go_run: assert property (wrCtl && pwdata[9] && pwdata[3] && !pwdata[10]
    && ctlQ[3] |-> ##[1:3] txRun) else $error("tx did not start");
  a_ptr_word_align: assert property (psel && penable && pready && !pwrite
    && paddr == RXQ_PTR_OFS |-> prdata[1:0] == 2'h0) else $error("pointer low bits set");
endmodule // eth_mac_control_checker

bind eth_mac_control eth_mac_control_checker u_chk (.core_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .macTxEn, .macTxd, .macRxd, .phyTxd,
  .rxEnable, .mgmtMdc, .mgmtMdioOut, .mgmtMdioOe_b, .mdioOut, .phyRxDv, .macRxDv, .rxFifoFlush,
  .txFifoFlush, .txQueueRestart, .txRun, .fullDuplex, .loopClkEn, .phyTxEn, .phyLoopback,
  .forceCollision, .mdc, .mdioOe_b);

/* File: testbench/phy_model.sv */
// behavioural phy sending receive frames with short idle gaps
// assumes the mac samples the nibble on the rising core clock
module phy_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] frameLen,
  output logic [3:0] phyRxd,
  output logic phyRxDv
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left = 8'h00;
  initial begin
    phyRxd = 4'h0;
    phyRxDv = 1'b0;
  end
  // idle nibble toggles so stale data never looks valid
  always @(posedge core_clk) begin
    left <= (go && left == 8'h00) ? frameLen + 8'h04 : left - {7'h0, left != 8'h00};
    phyRxDv <= left > 8'h04;
    phyRxd <= left > 8'h04 ? left[3:0] ^ 4'ha : ~phyRxd;
  end
endmodule // phy_model

/* File: testbench/eth_mac_control_tb_top.sv */
// self-checking bench for the mac control block with a phy model
// assumes the checker is bound and pready ends every apb transfer
module eth_mac_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import eth_ctl_pkg::*;
  logic core_clk, rst_b, psel, penable, pwrite, macTxEn, txFrameActive, rxBufferUsed;
  logic rxDescWrap, fullDuplexCfg, mgmtMdc, mgmtMdioOut, mgmtMdioOe_b, phyRxDv, pready;
  logic pslverr, macRxDv, rxEnable, rxFifoFlush, txFifoFlush, txQueueRestart, txRun;
  logic fullDuplex, loopClkEn, phyTxEn, phyLoopback, forceCollision, mdc, mdioOut;
  logic mdioOe_b, go, se;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, seed, bg, v, base;
  logic [3:0] macTxd, macRxd, phyRxd, phyTxd, statEvent;
  logic [7:0] frameLen;
  int n_errors, checks, cyc;
  eth_mac_control u_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .macTxd, .macTxEn, .txFrameActive, .rxBufferUsed,
    .rxDescWrap, .fullDuplexCfg, .statEvent, .macRxd, .macRxDv, .rxEnable, .rxFifoFlush,
    .txFifoFlush, .txQueueRestart, .txRun, .fullDuplex, .loopClkEn, .phyRxd, .phyRxDv,
    .phyTxd, .phyTxEn, .phyLoopback, .forceCollision, .mgmtMdc, .mgmtMdioOut,
    .mgmtMdioOe_b, .mdc, .mdioOut, .mdioOe_b);
  phy_model u_phy (.core_clk, .go, .frameLen, .phyRxd, .phyRxDv);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] ptrAt(input logic [31:0] b, input int i);
    return (b & 32'hffff_fffc) + 32'(i << DESC_STRIDE_LSB);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic use_buf(input logic w);
    @(posedge core_clk);
    rxBufferUsed <= 1'b1;
    rxDescWrap <= w;
    @(posedge core_clk);
    rxBufferUsed <= 1'b0;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    bg <= xs(bg);
    {mgmtMdioOe_b, mgmtMdioOut, mgmtMdc, macTxEn, macTxd} <= bg[7:0];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, txFrameActive, rxBufferUsed, rxDescWrap} = '0;
    {fullDuplexCfg, go, macTxEn, mgmtMdc, mgmtMdioOut, mgmtMdioOe_b} = '0;
    {paddr, pwdata, macTxd, statEvent, v} = '0;
    frameLen = 8'h10;
    seed = 32'haeba;
    bg = 32'haeba;
    {n_errors, checks, cyc} = '0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    go <= 1'b1;
    @(posedge core_clk);
    rdc(NET_CTRL_OFS, 32'h0, "ctrl reset");
    rdc(RXQ_PTR_OFS, RXQ_RESET, "ptr reset");
    chk("oe reset", 32'h1, mdioOe_b);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      fullDuplexCfg <= seed[12];
      frameLen <= {4'h0, seed[19:16]} + 8'h02;
      // rx and tx off across loopback change
      bus(1'b1, NET_CTRL_OFS, v & ~32'hc);
      bus(1'b1, NET_CTRL_OFS, seed & 32'h7f3);
      v = seed & 32'h7ff;
      bus(1'b1, NET_CTRL_OFS, v);
      rdc(NET_CTRL_OFS, v & CTRL_STORE_MASK, "ctrl readback");
      chk("loopback pin", v[0], phyLoopback);
    end
    bus(1'b1, NET_CTRL_OFS, v & ~32'hc);
    bus(1'b1, NET_CTRL_OFS, 32'h0);
    $display("test control done");
    fullDuplexCfg <= 1'b0;
    bus(1'b1, NET_CTRL_OFS, 32'h104);
    for (int i = 0; i < 60 && forceCollision !== 1'b1; i++) @(posedge core_clk);
    chk("collision", 32'h1, forceCollision);
    seed = xs(seed);
    base = (seed & 32'hffff_fff8) | 32'h3;
    bus(1'b1, RXQ_PTR_OFS, base);
    rdc(RXQ_PTR_OFS, ptrAt(base, 0), "ptr base");
    repeat (3) use_buf(1'b0);
    rdc(RXQ_PTR_OFS, ptrAt(base, 3), "ptr step");
    bus(1'b1, NET_CTRL_OFS, 32'h0);
    rdc(RXQ_PTR_OFS, ptrAt(base, 3), "ptr rx off");
    use_buf(1'b1);
    rdc(RXQ_PTR_OFS, ptrAt(base, 0), "ptr wrap bit");
    repeat (1023) use_buf(1'b0);
    rdc(RXQ_PTR_OFS, ptrAt(base, 1023), "ptr last");
    use_buf(1'b0);
    rdc(RXQ_PTR_OFS, ptrAt(base, 0), "ptr wrap count");
    $display("test pointer done");
    seed = xs(seed);
    bus(1'b1, NET_CTRL_OFS, 32'h80);
    bus(1'b1, STATS_BASE_OFS, seed);
    rdc(STATS_BASE_OFS, {16'h0, seed[15:0]}, "stat write");
    bus(1'b1, NET_CTRL_OFS, 32'h0);
    bus(1'b1, STATS_BASE_OFS, ~seed);
    rdc(STATS_BASE_OFS, {16'h0, seed[15:0]}, "stat locked");
    bus(1'b1, NET_CTRL_OFS, 32'h40);
    rdc(STATS_BASE_OFS, {16'h0, seed[15:0] + 16'h1}, "stat inc");
    bus(1'b1, NET_CTRL_OFS, 32'h20);
    @(posedge core_clk);
    statEvent <= 4'hf;
    @(posedge core_clk);
    statEvent <= 4'h0;
    bus(1'b1, NET_CTRL_OFS, 32'h40);
    for (int i = 0; i < 4; i++) rdc(STATS_BASE_OFS + 8'(4 * i), 32'h2, "stat");
    bus(1'b0, 8'h08, 32'h0);
    chk("unmapped err", 32'h1, se);
    $display("test stats done");
    bus(1'b1, NET_CTRL_OFS, 32'h8);
    txFrameActive <= 1'b1;
    bus(1'b1, NET_CTRL_OFS, 32'h208);
    repeat (3) @(posedge core_clk);
    chk("tx run", 32'h1, txRun);
    bus(1'b1, NET_CTRL_OFS, 32'h408);
    repeat (4) @(posedge core_clk);
    chk("tx halting", 32'h1, txRun);
    txFrameActive <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("tx halted", 32'h0, txRun);
    bus(1'b1, NET_CTRL_OFS, 32'h208);
    bus(1'b1, NET_CTRL_OFS, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("tx off", 32'h0, txRun);
    $display("test transmit done");
    complete_run();
  end
endmodule // eth_mac_control_tb_top
